// ===== rtl/tlb_stage_defines.svh
// Purpose: offsets, field positions and reset values of the staging regs
// Assumes: register numbers are coprocessor register indices
// Notes:   definitions only
`ifndef TLB_STAGE_DEFINES_SVH
`define TLB_STAGE_DEFINES_SVH
// ***********************************************************************
// register numbers
// ***********************************************************************
`define REG_EVEN_LOW     5'h02
`define REG_ODD_LOW      5'h03
`define REG_PT_POINTER   5'h04
// ***********************************************************************
// entry-low fields
// ***********************************************************************
`define LO_RSVD_HI       31
`define LO_RSVD_LO       30
`define LO_ZERO_HI       29
`define LO_ZERO_LO       26
`define LO_FRAME_HI      25
`define LO_FRAME_LO      6
`define LO_ATTR_HI       5
`define LO_ATTR_LO       3
`define LO_WE_BIT        2
`define LO_VALID_BIT     1
`define LO_GLOBAL_BIT    0
`define LO_RESET         30'h0000_0000
// ***********************************************************************
// pointer fields
// ***********************************************************************
`define PTR_BASE_HI      31
`define PTR_BASE_LO      23
`define PTR_PAIR_HI      22
`define PTR_PAIR_LO      4
`define VA_PAIR_HI       31
`define VA_PAIR_LO       13
`define PTR_BASE_RESET   9'h000
`define PTR_PAIR_RESET   19'h00000
`define ATTR_CACHED      3'h3
`define ATTR_UNCACHED    3'h2
`endif

// ===== rtl/tlb_stage_pkg.sv
// Purpose: types shared by the staging register files
// Assumes: nothing
// Notes:   constants live in tlb_stage_defines.svh
package tlb_stage_pkg;
   // ********************************************************************
   // types
   // ********************************************************************
   typedef enum logic [1:0] {
      op_none,
      op_read,
      op_write_indexed,
      op_write_random
   } tlb_op_t;
   typedef enum logic {
      cache_uncached,
      cache_write_through
   } cache_mode_t;
endpackage

// ===== rtl/cache_attr_map.sv
// Purpose: fold the 3-bit cache attribute to the two implemented codes
// Assumes: combinational use only
// Notes:   none
`timescale 1ns/100ps
`include "tlb_stage_defines.svh"
module cache_attr_map
   import tlb_stage_pkg::*;
(
   // raw attribute
   input  wire logic [2:0]  attr_in,
   // folded attribute
   output logic [2:0]       attr_out,
   output cache_mode_t      mode
);
   // ********************************************************************
   // mapping
   // ********************************************************************
   always_comb begin
      case (attr_in)
         3'h2, 3'h7: begin
            attr_out = `ATTR_UNCACHED;
            mode     = cache_uncached;
         end
         default: begin
            attr_out = `ATTR_CACHED;
            mode     = cache_write_through;
         end
      endcase
   end
endmodule // cache_attr_map

// ===== rtl/page_access_check.sv
// Purpose: access checks for one matched page half
// Assumes: match already found by the tlb array
// Notes:   combinational
`timescale 1ns/100ps
module page_access_check (
   // matched entry
   input  wire logic        hit,
   input  wire logic        valid,
   input  wire logic        write_enable,
   input  wire logic        is_store,
   // exceptions
   output logic             invalid_exc,
   output logic             modified_exc
);
   // ********************************************************************
   // checks
   // ********************************************************************
   always_comb begin
      invalid_exc  = hit && !valid;
      // invalid outranks modified
      modified_exc = hit && valid && is_store && !write_enable;
   end
endmodule // page_access_check

// ===== rtl/tlb_entry_staging_regs.sv
// Purpose: coprocessor staging registers between software and the tlb
// Assumes: cp0 move port and tlb array port synchronous to clock
// Notes:   tlb match itself lives in the array; this block checks hits
//
// Overview of operation
// - read loads both, writes copy both
// - first register even page, second odd
// - registers undefined after address or tlb exceptions
// - bits 31:30 ignore writes, read zero
// - frame number gives physical address 31:12
// - clear write-enable makes stores raise modified
// - clear valid makes accesses raise invalid
// - written global is AND of both
// - global entry skips address-space compare
// - tlb read copies global into both
// - attribute codes select cached or uncached
// - only codes 3 and 2 implemented
// - tlb exceptions capture va 31:13 into pointer
// - faulting pair read-only to software
// - faulting pair undefined after address error
// - table base software-owned, hardware never touches
// - pointer bits 3:0 read zero
`timescale 1ns/100ps
`include "tlb_stage_defines.svh"
module tlb_entry_staging_regs
   import tlb_stage_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         arst_n,
   // coprocessor move port
   input  wire logic         cp0_write,
   input  wire logic [4:0]   cp0_reg,
   input  wire logic [31:0]  cp0_wdata,
   output logic [31:0]       cp0_rdata,
   // tlb instructions
   input  wire tlb_op_t      tlb_op,
   // tlb array: read data of selected entry
   input  wire logic [25:0]  tlb_rd_even,
   input  wire logic [25:0]  tlb_rd_odd,
   input  wire logic         tlb_rd_global,
   // tlb array: write data
   output logic              tlb_we,
   output logic [25:0]       tlb_wr_even,
   output logic [25:0]       tlb_wr_odd,
   output logic              tlb_wr_global,
   // match and exception side
   input  wire logic         tlb_exc,
   input  wire logic [31:0]  bad_vaddr,
   input  wire logic         match_hit,
   input  wire logic         match_odd,
   input  wire logic         match_global,
   input  wire logic         space_id_eq,
   input  wire logic         access_store,
   input  wire logic [25:0]  match_even,
   input  wire logic [25:0]  match_odd_data,
   output logic              match_ok,
   output logic [19:0]       phys_frame,
   output logic [2:0]        phys_attr,
   output logic              phys_uncached,
   output logic              exc_invalid,
   output logic              exc_modified
);
   // ********************************************************************
   // state
   // ********************************************************************
   // each half stored as frame, attr, we, valid, global (26 bits)
   // bits 29:26 kept as written so software sees its own zeros
   logic [29:0]  even_page_entry_low;
   logic [29:0]  odd_page_entry_low;
   logic [29:0]  next_even;
   logic [29:0]  next_odd;
   logic [8:0]   page_table_base;
   logic [18:0]  faulting_page_pair;
   logic [8:0]   next_base;
   logic [18:0]  next_pair;
   logic [31:0]  next_rdata;
   logic         next_we;
   logic [25:0]  next_wr_even;
   logic [25:0]  next_wr_odd;
   logic         next_wr_global;
   logic         next_ok;
   logic [19:0]  next_frame;
   logic [2:0]   next_attr;
   logic         next_uncached;
   logic         next_inv;
   logic         next_mod;
   // ********************************************************************
   // helpers
   // ********************************************************************
   // register-number decode, used for both read and write paths
   function automatic logic sel(input logic [4:0] r, input logic [4:0] n);
      sel = (r == n);
   endfunction
   logic [25:0]  hit_half;
   logic [2:0]   folded_attr;
   cache_mode_t  folded_mode;
   logic         chk_inv;
   logic         chk_mod;
   always_comb begin
      hit_half = match_odd ? match_odd_data : match_even;
      // qualified here so the check cell feeds no loop back
      next_ok  = match_hit && (match_global || space_id_eq);
   end
   cache_attr_map u_attr (
      .attr_in  (hit_half[5:3]),
      .attr_out (folded_attr),
      .mode     (folded_mode)
   );
   page_access_check u_check (
      .hit          (next_ok),
      .valid        (hit_half[`LO_VALID_BIT]),
      .write_enable (hit_half[`LO_WE_BIT]),
      .is_store     (access_store),
      .invalid_exc  (chk_inv),
      .modified_exc (chk_mod)
   );
   // ********************************************************************
   // next-state logic
   // ********************************************************************
   always_comb begin
      next_even      = even_page_entry_low;
      next_odd       = odd_page_entry_low;
      next_base      = page_table_base;
      next_pair      = faulting_page_pair;
      next_we        = 1'b0;
      next_wr_even   = even_page_entry_low[25:0];
      next_wr_odd    = odd_page_entry_low[25:0];
      next_wr_global = even_page_entry_low[`LO_GLOBAL_BIT]
                     & odd_page_entry_low[`LO_GLOBAL_BIT];
      // software moves; bits 31:30 dropped
      if (cp0_write && sel(cp0_reg, `REG_EVEN_LOW)) begin
         next_even = cp0_wdata[29:0];
      end
      if (cp0_write && sel(cp0_reg, `REG_ODD_LOW)) begin
         next_odd = cp0_wdata[29:0];
      end
      if (cp0_write && sel(cp0_reg, `REG_PT_POINTER)) begin
         // faulting pair and low bits not writable
         next_base = cp0_wdata[`PTR_BASE_HI:`PTR_BASE_LO];
      end
      case (tlb_op)
         op_read: begin
            next_even = {4'h0, tlb_rd_even[25:1], tlb_rd_global};
            next_odd  = {4'h0, tlb_rd_odd[25:1], tlb_rd_global};
         end
         op_write_indexed, op_write_random: begin
            next_we = 1'b1;
         end
         default: begin
         end
      endcase
      // exceptions leave entry-low values as they are (allowed undefined)
      if (tlb_exc) begin
         next_pair = bad_vaddr[`VA_PAIR_HI:`VA_PAIR_LO];
      end
      // move-from data
      next_rdata = 32'h0000_0000;
      if (sel(cp0_reg, `REG_EVEN_LOW)) begin
         next_rdata = {2'h0, next_even};
      end else if (sel(cp0_reg, `REG_ODD_LOW)) begin
         next_rdata = {2'h0, next_odd};
      end else if (sel(cp0_reg, `REG_PT_POINTER)) begin
         next_rdata = {next_base, next_pair, 4'h0};
      end
      // match qualification
      next_frame    = hit_half[`LO_FRAME_HI:`LO_FRAME_LO];
      next_attr     = folded_attr;
      next_uncached = (folded_mode == cache_uncached);
      next_inv      = chk_inv;
      next_mod      = chk_mod;
   end
   // ********************************************************************
   // registers
   // ********************************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         even_page_entry_low <= `LO_RESET;
         odd_page_entry_low  <= `LO_RESET;
         page_table_base     <= `PTR_BASE_RESET;
         faulting_page_pair  <= `PTR_PAIR_RESET;
         cp0_rdata           <= 32'h0000_0000;
         tlb_we              <= 1'b0;
         tlb_wr_even         <= 26'h000_0000;
         tlb_wr_odd          <= 26'h000_0000;
         tlb_wr_global       <= 1'b0;
         match_ok            <= 1'b0;
         phys_frame          <= 20'h0_0000;
         phys_attr           <= 3'h0;
         phys_uncached       <= 1'b0;
         exc_invalid         <= 1'b0;
         exc_modified        <= 1'b0;
      end else begin
         even_page_entry_low <= next_even;
         odd_page_entry_low  <= next_odd;
         page_table_base     <= next_base;
         faulting_page_pair  <= next_pair;
         cp0_rdata           <= next_rdata;
         tlb_we              <= next_we;
         tlb_wr_even         <= next_wr_even;
         tlb_wr_odd          <= next_wr_odd;
         tlb_wr_global       <= next_wr_global;
         match_ok            <= next_ok;
         phys_frame          <= next_frame;
         phys_attr           <= next_attr;
         phys_uncached       <= next_uncached;
         exc_invalid         <= next_inv;
         exc_modified        <= next_mod;
      end
   end
endmodule // tlb_entry_staging_regs

// ===== bench/tlb_array_model.sv
// Purpose: behavioural tlb array, one selected entry
// Assumes: index and random selection lie outside the block
// Notes:   reads return an inverted bit 0 so it must be ignored
`timescale 1ns/100ps
module tlb_array_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // write side
   input  wire logic        tlb_we,
   input  wire logic [25:0] tlb_wr_even,
   input  wire logic [25:0] tlb_wr_odd,
   input  wire logic        tlb_wr_global,
   // read side
   output logic [25:0]      tlb_rd_even,
   output logic [25:0]      tlb_rd_odd,
   output logic             tlb_rd_global
);
   // ****************
   // entry storage
   // ****************
   logic [25:0] even;
   logic [25:0] odd;
   logic        glob;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         even <= 26'h0;
         odd <= 26'h0;
         glob <= 1'b0;
      end else if (tlb_we) begin
         even <= tlb_wr_even;
         odd <= tlb_wr_odd;
         glob <= tlb_wr_global;
      end
   end
   // stale per-half bit 0 differs from the entry global on purpose
   assign tlb_rd_even = {even[25:1], ~glob};
   assign tlb_rd_odd = {odd[25:1], ~glob};
   assign tlb_rd_global = glob;
endmodule // tlb_array_model

// ===== bench/tlb_stage_props.sv
// Purpose: port assertions for the staging registers
// Assumes: one clock, async low reset
// Notes:   bound to every staging register instance
`timescale 1ns/100ps
`include "tlb_stage_defines.svh"
module tlb_stage_props
   import tlb_stage_pkg::*;
(
   // clock, cp0 and tlb ops
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic [4:0]  cp0_reg,
   input wire logic [31:0] cp0_rdata,
   input wire tlb_op_t     tlb_op,
   input wire logic        tlb_we,
   input wire logic [25:0] tlb_wr_even,
   input wire logic [25:0] tlb_wr_odd,
   input wire logic        tlb_wr_global,
   input wire logic        tlb_exc,
   input wire logic [31:0] bad_vaddr,
   // match side
   input wire logic        match_hit,
   input wire logic        match_odd,
   input wire logic        match_global,
   input wire logic        space_id_eq,
   input wire logic        access_store,
   input wire logic [25:0] match_even,
   input wire logic        match_ok,
   input wire logic [2:0]  phys_attr,
   input wire logic        phys_uncached,
   input wire logic        exc_invalid,
   input wire logic        exc_modified
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire logic ok = match_hit && (match_global || space_id_eq);
   wire logic ev = ok && !match_odd;
   wire logic wr = tlb_op == op_write_indexed || tlb_op == op_write_random;
   wire logic [18:0] va = bad_vaddr[31:13];
   a_write_strobe: assert property (wr |=> tlb_we)
      else $error("write op gave no strobe");
   a_strobe_cause: assert property (tlb_we |-> $past(wr))
      else $error("strobe without write op");
   a_global_and: assert property (tlb_we |->
      tlb_wr_global == (tlb_wr_even[0] & tlb_wr_odd[0]))
      else $error("written global not and");
   a_lo_rsvd: assert property (cp0_reg inside {`REG_EVEN_LOW,
      `REG_ODD_LOW} |=> cp0_rdata[31:30] == 2'h0)
      else $error("reserved bits not zero");
   a_ptr_low: assert property (cp0_reg == `REG_PT_POINTER
      |=> cp0_rdata[3:0] == 4'h0)
      else $error("pointer low bits not zero");
   a_pair_capture: assert property (tlb_exc && cp0_reg == `REG_PT_POINTER
      |=> cp0_rdata[22:4] == $past(va))
      else $error("fault pair not captured");
   a_skip_address_space_id: assert property (match_hit && match_global
      |=> match_ok)
      else $error("global entry missed");
   a_invalid_page: assert property (ev && !match_even[1]
      |=> exc_invalid)
      else $error("invalid page not flagged");
   a_store_guard: assert property (ev && match_even[1] && access_store
      && !match_even[2] |=> exc_modified && !exc_invalid)
      else $error("store to clean page not flagged");
   a_attr_fold: assert property (ok |=> phys_attr inside {3'h2, 3'h3}
      && phys_uncached == (phys_attr == 3'h2))
      else $error("attribute not folded");
   c_write: cover property (wr ##1 tlb_we);
   c_fault: cover property (tlb_exc);
   c_invalid: cover property (exc_invalid);
endmodule // tlb_stage_props
bind tlb_entry_staging_regs tlb_stage_props u_props (.*);

// ===== bench/test_tlb_entry_staging_regs.sv
// Purpose: self-checking bench for the staging registers
// Assumes: tlb array modelled as one selected entry
// Notes:   fixed seed random data plus corner cases
`timescale 1ns/100ps
`include "tlb_stage_defines.svh"
module test_tlb_entry_staging_regs
   import tlb_stage_pkg::*;
;
   logic        clock, arst_n, cp0_write, tlb_exc, match_hit, match_odd;
   logic        match_global, space_id_eq, access_store, tlb_we, ok;
   logic        tlb_wr_global, tlb_rd_global, match_ok, phys_uncached;
   logic        exc_invalid, exc_modified;
   logic [4:0]  cp0_reg, f;
   logic [2:0]  phys_attr;
   logic [19:0] phys_frame;
   logic [18:0] pair;
   logic [25:0] tlb_rd_even, tlb_rd_odd, tlb_wr_even, tlb_wr_odd, h;
   logic [25:0] match_even, match_odd_data;
   logic [31:0] cp0_wdata, cp0_rdata, bad_vaddr, d0, d1, p;
   tlb_op_t     tlb_op;
   int          fail_count = 0, n_tests = 0, cycles = 0;
   tlb_entry_staging_regs DUT (.*);
   tlb_array_model u_tlb (.*);
   // ****************
   // helpers
   // ****************
   function automatic logic [2:0] fold(input logic [2:0] c);
      return (c == 3'h2 || c == 3'h7) ? 3'h2 : 3'h3;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (fail_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] r, input logic [31:0] v);
      @(posedge clock);
      cp0_write <= 1'b1;
      cp0_reg <= r;
      cp0_wdata <= v;
      @(posedge clock);
      cp0_write <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] r, input logic [31:0] e);
      @(posedge clock);
      cp0_reg <= r;
      @(posedge clock);
      @(negedge clock);
      chk(cp0_rdata, e);
   endtask
   task automatic op(input tlb_op_t o);
      @(posedge clock);
      tlb_op <= o;
      @(posedge clock);
      tlb_op <= op_none;
      @(negedge clock);
   endtask
   // ****************
   // clock, timeout, sequence
   // ****************
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      {arst_n, cp0_write, tlb_exc, match_hit, match_odd} = 5'h0;
      {match_global, space_id_eq, access_store} = 3'h0;
      {cp0_reg, cp0_wdata, bad_vaddr, match_even, match_odd_data} = 0;
      tlb_op = op_none;
      pair = 19'h0;
      void'($urandom(32'hb129c12f));
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         d0 = $urandom | ((k == 0) ? 32'hc000_0001 : 32'h0);
         d1 = $urandom | ((k == 0) ? 32'hc000_0001 : 32'h0);
         d0[29:26] = 4'h0;
         d1[29:26] = 4'h0;
         wr(`REG_EVEN_LOW, d0);
         wr(`REG_ODD_LOW, d1);
         rd(`REG_EVEN_LOW, {2'h0, d0[29:0]});
         rd(`REG_ODD_LOW, {2'h0, d1[29:0]});
         op(k[0] ? op_write_random : op_write_indexed);
         chk(32'(tlb_we), 32'h1);
         chk(32'(tlb_wr_even), 32'(d0[25:0]));
         chk(32'(tlb_wr_odd), 32'(d1[25:0]));
         chk(32'(tlb_wr_global), 32'(d0[0] & d1[0]));
         wr(`REG_EVEN_LOW, 32'h0);
         op(op_read);
         rd(`REG_EVEN_LOW, {6'h0, d0[25:1], d0[0] & d1[0]});
         rd(`REG_ODD_LOW, {6'h0, d1[25:1], d0[0] & d1[0]});
         p = $urandom & 32'hffff_fff0;
         wr(`REG_PT_POINTER, p);
         rd(`REG_PT_POINTER, {p[31:23], pair, 4'h0});
         @(posedge clock);
         bad_vaddr <= $urandom;
         tlb_exc <= 1'b1;
         @(posedge clock);
         tlb_exc <= 1'b0;
         pair = bad_vaddr[31:13];
         rd(`REG_PT_POINTER, {p[31:23], pair, 4'h0});
      end
      rd(5'h1f, 32'h0);
      for (int i = 0; i < 24; i++) begin
         f = 5'($urandom) | {4'h0, i[3]};
         h = 26'($urandom);
         h[5:3] = 3'(i);
         @(posedge clock);
         {access_store, space_id_eq, match_global, match_odd} <= f[4:1];
         match_hit <= f[0];
         match_even <= f[1] ? ~h : h;
         match_odd_data <= f[1] ? h : ~h;
         @(posedge clock);
         @(negedge clock);
         ok = f[0] & (f[2] | f[3]);
         chk(32'(match_ok), 32'(ok));
         chk(32'(exc_invalid), 32'(ok & ~h[1]));
         chk(32'(exc_modified), 32'(ok & h[1] & f[4] & ~h[2]));
         if (ok) begin
            chk(32'(phys_frame), 32'(h[25:6]));
            chk(32'(phys_attr), 32'(fold(h[5:3])));
            chk(32'(phys_uncached), 32'(h[5:3] inside {2, 7}));
         end
      end
      close_out();
   end
endmodule // test_tlb_entry_staging_regs
